// ===== include/sysctl_cfg.svh
`ifndef SYSCTL_CFG_SVH
`define SYSCTL_CFG_SVH
// register offsets (byte addresses on the plain port)
`define ADDR_SYSTEM_CONTROL 8'h09
`define ADDR_RESERVED_ZERO_A 8'h0A
`define ADDR_OFFSET_CAL_LOW 8'h0B
`define ADDR_OFFSET_CAL_HIGH 8'h0C
// reset values
`define RST_SYSTEM_CONTROL 8'h10
`define RST_RESERVED_ZERO_A 8'h00
`define RST_OFFSET_CAL_LOW 8'h00
`define RST_OFFSET_CAL_HIGH 8'h00
// reset levels of the registered controls: code 10 gives 8 samples, no burn-out source
`define RST_SAMPLE_COUNT 5'h08
`define RST_BURNOUT 4'h1
// field positions of system_control
`define MON_HI 7
`define MON_LO 5
`define CAL_HI 4
`define CAL_LO 3
`define TIMEOUT_BIT 2
`define CHECK_BIT 1
`define STATUS_BIT 0
// amplifier enable code needed by the temperature sensor
`define AMP_EN_ACTIVE 2'h1
// largest gain code legal for the temperature sensor (gain 4)
`define TEMP_GAIN_MAX 3'h2
`endif

// ===== include/sysctl_pkg.sv
package sysctl_pkg;
  typedef enum logic [2:0] {
    MON_OFF = 3'h0,
    MON_MID_SUPPLY = 3'h1,
    MON_TEMP = 3'h2,
    MON_ANALOG_SUPPLY = 3'h3,
    MON_DIGITAL_SUPPLY = 3'h4,
    MON_BURN_LOW = 3'h5,
    MON_BURN_MID = 3'h6,
    MON_BURN_HIGH = 3'h7
  } monitor_t;
  typedef enum logic [1:0] {
    AVG_1 = 2'h0,
    AVG_4 = 2'h1,
    AVG_8 = 2'h2,
    AVG_16 = 2'h3
  } avg_t;
  typedef enum logic [3:0] {
    BURN_NONE = 4'h1,
    BURN_SMALL = 4'h2,
    BURN_MEDIUM = 4'h4,
    BURN_LARGE = 4'h8
  } burn_t;
endpackage

// ===== hw/monitor_decode.sv
`timescale 1ns/10ps
`include "sysctl_cfg.svh"
// decodes the monitor selector into analog control levels
module monitor_decode (
  // selector and user settings
  input wire logic [2:0] monitor_source_select,
  input wire logic [2:0] user_gain,
  // decoded controls
  output logic inputs_to_mid_supply,
  output logic temp_sensor_route,
  output logic analog_supply_route,
  output logic digital_supply_route,
  output logic input_mux_open,
  output logic [2:0] effective_gain,
  output sysctl_pkg::burn_t burnout_select
);
  // one decode per selector code
  always_comb begin
    inputs_to_mid_supply = (monitor_source_select == sysctl_pkg::MON_MID_SUPPLY); // RULE1
    temp_sensor_route = (monitor_source_select == sysctl_pkg::MON_TEMP); // RULE2
    analog_supply_route = (monitor_source_select == sysctl_pkg::MON_ANALOG_SUPPLY); // RULE3
    digital_supply_route = (monitor_source_select == sysctl_pkg::MON_DIGITAL_SUPPLY); // RULE3
    input_mux_open = inputs_to_mid_supply | temp_sensor_route | analog_supply_route | digital_supply_route; // RULE6
    // supply monitors force unity gain, code zero
    if (analog_supply_route || digital_supply_route) begin
      effective_gain = 3'h0; // RULE5
    end else begin
      effective_gain = user_gain;
    end
    case (monitor_source_select)
      sysctl_pkg::MON_BURN_LOW: burnout_select = sysctl_pkg::BURN_SMALL; // RULE4
      sysctl_pkg::MON_BURN_MID: burnout_select = sysctl_pkg::BURN_MEDIUM; // RULE4
      sysctl_pkg::MON_BURN_HIGH: burnout_select = sysctl_pkg::BURN_LARGE; // RULE4
      default: burnout_select = sysctl_pkg::BURN_NONE;
    endcase
  end
endmodule // monitor_decode

// ===== hw/avg_count_decode.sv
`timescale 1ns/10ps
// turns the calibration averaging code into a sample count
module avg_count_decode (
  // code
  input wire logic [1:0] calibration_average_count,
  // samples to average
  output logic [4:0] sample_count
);
  // code to count
  always_comb begin
    case (calibration_average_count)
      sysctl_pkg::AVG_1: sample_count = 5'h01; // RULE8
      sysctl_pkg::AVG_4: sample_count = 5'h04; // RULE8
      sysctl_pkg::AVG_8: sample_count = 5'h08; // RULE8
      sysctl_pkg::AVG_16: sample_count = 5'h10; // RULE8
      default: sample_count = 5'h08;
    endcase
  end
endmodule // avg_count_decode

// ===== hw/adc_system_control_regs.sv
`timescale 1ns/10ps
`include "sysctl_cfg.svh"
// Overview of operation
// RULE1 - monitor selector bits 7:5 reset disabled; 001 shorts amplifier inputs to mid-supply
// RULE2 - code 010 routes temperature sensor, user gain; amplifier enable must be 01
// RULE3 - codes 011 and 100 measure analog and digital supply over four, unity gain
// RULE4 - codes 101, 110, 111 enable burn-out sources at three rising settings
// RULE5 - supply monitor codes force unity gain whatever the gain field holds
// RULE6 - mid-supply, temperature and supply selections open all input switches
// RULE7 - host keeps gain four or less while measuring temperature
// RULE8 - bits 4:3 pick 1, 4, 8 or 16 calibration samples, default code 10
// RULE9 - bit 2 enables serial timeout, resets to zero
// RULE10 - bit 1 appends check byte over result plus status byte, resets off
// RULE11 - bit 0 sends status byte before each result, resets off
// RULE12 - address 0Ah is reserved, reads 00h; host writes only 00h
// RULE13 - address 0Bh holds low offset byte, resets to zero
// RULE14 - system control sits at 09h and resets to 10h
// RULE15 - address 0Ch holds upper offset byte, joined with low byte
// RULE16 - read-write fields read back last write or reset value
module adc_system_control_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // user settings from neighbouring registers
  input wire logic [2:0] user_gain,
  input wire logic [1:0] amplifier_enable,
  // analog controls
  output logic inputs_to_mid_supply,
  output logic temp_sensor_route,
  output logic analog_supply_route,
  output logic digital_supply_route,
  output logic input_mux_open,
  output logic [2:0] effective_gain,
  output logic [3:0] burnout_select,
  // digital controls
  output logic [4:0] cal_sample_count,
  output logic timeout_enable,
  output logic check_byte_append,
  output logic status_byte_prepend,
  output logic [15:0] offset_correction_value,
  // configuration warnings
  output logic temp_config_error
);
  logic [7:0] sysctl_q;
  logic [7:0] ofs_low_q;
  logic [7:0] ofs_high_q;
  logic [7:0] rdata_d;
  logic mid_d;
  logic temp_d;
  logic asup_d;
  logic dsup_d;
  logic open_d;
  logic [2:0] gain_d;
  sysctl_pkg::burn_t burn_d;
  logic [4:0] count_d;
  logic wr_sys;
  logic wr_low;
  logic wr_high;

  // write decode
  assign wr_sys = reg_write && (reg_addr == `ADDR_SYSTEM_CONTROL); // RULE14
  assign wr_low = reg_write && (reg_addr == `ADDR_OFFSET_CAL_LOW); // RULE13
  assign wr_high = reg_write && (reg_addr == `ADDR_OFFSET_CAL_HIGH); // RULE15

  // system control register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sysctl_q <= `RST_SYSTEM_CONTROL; // RULE14
    end else if (wr_sys) begin
      sysctl_q <= reg_wdata; // RULE16
    end
  end

  // offset low byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ofs_low_q <= `RST_OFFSET_CAL_LOW; // RULE13
    end else if (wr_low) begin
      ofs_low_q <= reg_wdata; // RULE16
    end
  end

  // offset high byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ofs_high_q <= `RST_OFFSET_CAL_HIGH;
    end else if (wr_high) begin
      ofs_high_q <= reg_wdata; // RULE15
    end
  end

  // read mux; reserved and unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        `ADDR_SYSTEM_CONTROL: rdata_d = sysctl_q; // RULE16
        `ADDR_RESERVED_ZERO_A: rdata_d = `RST_RESERVED_ZERO_A; // RULE12
        `ADDR_OFFSET_CAL_LOW: rdata_d = ofs_low_q; // RULE16
        `ADDR_OFFSET_CAL_HIGH: rdata_d = ofs_high_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // monitor selector decode
  monitor_decode i_monitor_decode (
    .monitor_source_select(sysctl_q[`MON_HI:`MON_LO]),
    .user_gain(user_gain),
    .inputs_to_mid_supply(mid_d),
    .temp_sensor_route(temp_d),
    .analog_supply_route(asup_d),
    .digital_supply_route(dsup_d),
    .input_mux_open(open_d),
    .effective_gain(gain_d),
    .burnout_select(burn_d)
  );

  // calibration averaging decode
  avg_count_decode i_avg_count_decode (
    .calibration_average_count(sysctl_q[`CAL_HI:`CAL_LO]),
    .sample_count(count_d)
  );

  // registered analog controls
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      inputs_to_mid_supply <= 1'b0;
      temp_sensor_route <= 1'b0;
      analog_supply_route <= 1'b0;
      digital_supply_route <= 1'b0;
      input_mux_open <= 1'b0;
      effective_gain <= 3'h0;
      burnout_select <= `RST_BURNOUT; // RULE4
    end else begin
      inputs_to_mid_supply <= mid_d; // RULE1
      temp_sensor_route <= temp_d; // RULE2
      analog_supply_route <= asup_d; // RULE3
      digital_supply_route <= dsup_d; // RULE3
      input_mux_open <= open_d; // RULE6
      effective_gain <= gain_d; // RULE5
      burnout_select <= burn_d; // RULE4
    end
  end

  // registered digital controls
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cal_sample_count <= `RST_SAMPLE_COUNT; // RULE8
      timeout_enable <= 1'b0;
      check_byte_append <= 1'b0;
      status_byte_prepend <= 1'b0;
      offset_correction_value <= 16'h0000;
    end else begin
      cal_sample_count <= count_d; // RULE8
      timeout_enable <= sysctl_q[`TIMEOUT_BIT]; // RULE9
      check_byte_append <= sysctl_q[`CHECK_BIT]; // RULE10
      status_byte_prepend <= sysctl_q[`STATUS_BIT]; // RULE11
      offset_correction_value <= {ofs_high_q, ofs_low_q}; // RULE15
    end
  end

  // flags temperature setup the host got wrong
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      temp_config_error <= 1'b0;
    end else begin
      temp_config_error <= temp_d && ((amplifier_enable != `AMP_EN_ACTIVE) || (user_gain > `TEMP_GAIN_MAX)); // RULE2 RULE7
    end
  end
endmodule // adc_system_control_regs

// ===== sim/sysctl_props.sv
`timescale 1ns/10ps
// watches the register port and the decoded controls
module sysctl_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // controls
  input wire logic [2:0] user_gain,
  input wire logic input_mux_open,
  input wire logic [2:0] effective_gain,
  input wire logic [3:0] burnout_select,
  input wire logic [4:0] cal_sample_count,
  input wire logic timeout_enable,
  input wire logic [15:0] offset_correction_value
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // a system control write reaches the outputs two edges after its strobe
  logic sys_wr;
  assign sys_wr = reg_write && reg_addr == 8'h09;
  chk_reserved_reads_zero: assert property (
    reg_read && reg_addr == 8'h0A |=> reg_rdata == 8'h00) else $error("reserved read not zero");
  chk_sysctl_read_back: assert property (
    sys_wr ##1 reg_read && reg_addr == 8'h09 |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback wrong");
  chk_sysctl_gap_read: assert property (
    sys_wr ##1 !reg_write ##1 reg_read && reg_addr == 8'h09 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("gap readback wrong");
  chk_supply_unity_gain: assert property (
    sys_wr && reg_wdata[7:5] == 3'h3 |=> ##1 effective_gain == 3'h0 && input_mux_open) else $error("supply gain");
  chk_temp_user_gain: assert property (
    sys_wr && reg_wdata[7:5] == 3'h2 |=> ##1 effective_gain == $past(user_gain)) else $error("temp gain");
  chk_burnout_level: assert property (
    sys_wr && reg_wdata[7] && reg_wdata[6:5] != 2'h0 |=> ##1
    burnout_select == 4'h1 << (3'($past(reg_wdata, 2) >> 5) - 3'h4)) else $error("burnout wrong");
  chk_cal_samples: assert property (
    sys_wr |=> ##1 cal_sample_count == (($past(reg_wdata, 2) & 8'h18) == 8'h00 ? 5'h01 :
    5'h02 << (($past(reg_wdata, 2) >> 3) & 8'h03))) else $error("cal count wrong");
  chk_timeout_bit: assert property (
    sys_wr |=> ##1 timeout_enable == (($past(reg_wdata, 2) >> 2) & 8'h01)) else $error("timeout wrong");
  chk_offset_bytes: assert property (
    reg_write && reg_addr == 8'h0C |=> ##1 offset_correction_value[15:8] == $past(reg_wdata, 2))
    else $error("offset high wrong");
  chk_reset_levels: assert property (
    $rose(rst_n) |-> cal_sample_count == 5'h08 && burnout_select == 4'h1) else $error("reset levels");
endmodule // sysctl_props

bind adc_system_control_regs sysctl_props i_sysctl_props (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .user_gain, .input_mux_open, .effective_gain, .burnout_select, .cal_sample_count,
  .timeout_enable, .offset_correction_value);

// ===== sim/host_model.sv
`timescale 1ns/10ps
// host side of the register port: one-cycle strobes launched after a rising edge
module host_model (
  // clock
  input wire logic sys_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata
);
  // idle port
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // write; address and data are scrambled once the strobe is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // write then read with no gap between the strobes; data taken in the cycle after the read
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] w, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    reg_wdata <= ~w;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
  // read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // host_model

// ===== sim/adc_system_control_regs_tb_top.sv
`timescale 1ns/10ps
// random and corner settings through the host model, outputs checked
module adc_system_control_regs_tb_top;
  logic sys_clk, rst_n, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, s, d;
  logic [2:0] user_gain, effective_gain, g;
  logic [1:0] amplifier_enable, a;
  logic inputs_to_mid_supply, temp_sensor_route, analog_supply_route, digital_supply_route, input_mux_open;
  logic timeout_enable, check_byte_append, status_byte_prepend, temp_config_error;
  logic [3:0] burnout_select;
  logic [4:0] cal_sample_count;
  logic [15:0] offset_correction_value, o;
  logic [20:0] ctl;
  integer seed;
  int errors = 0;
  int n_tests = 0;
  host_model i_host_model (.sys_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
  adc_system_control_regs i_adc_system_control_regs (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .user_gain, .amplifier_enable, .inputs_to_mid_supply, .temp_sensor_route,
    .analog_supply_route, .digital_supply_route, .input_mux_open, .effective_gain, .burnout_select,
    .cal_sample_count, .timeout_enable, .check_byte_append, .status_byte_prepend, .offset_correction_value,
    .temp_config_error);
  // all decoded controls in one word
  assign ctl = {inputs_to_mid_supply, temp_sensor_route, analog_supply_route, digital_supply_route,
    input_mux_open, effective_gain, burnout_select, cal_sample_count, timeout_enable, check_byte_append,
    status_byte_prepend, temp_config_error};
  // expected controls from a system control value
  function automatic logic [20:0] ctl_exp(input logic [7:0] v, input logic [2:0] gn, input logic [1:0] en);
    logic [2:0] m;
    m = v[7:5];
    return {m == 3'h1, m == 3'h2, m == 3'h3, m == 3'h4, m != 3'h0 && m < 3'h5,
      (m == 3'h3 || m == 3'h4) ? 3'h0 : gn, m > 3'h4 ? 4'h1 << (m - 3'h4) : 4'h1,
      v[4:3] == 2'h0 ? 5'h01 : 5'h02 << v[4:3], v[2:0],
      m == 3'h2 && (en != 2'h1 || gn > 3'h2)};
  endfunction
  task automatic chk(input string nm, input logic [20:0] seen, input logic [20:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // reset for six cycles, then reset values
  task automatic reset_check();
    rst_n <= 1'b0;
    user_gain <= 3'h0;
    amplifier_enable <= 2'h0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      i_host_model.rd(8'h09 + 8'(i), d);
      chk("reset read", 21'(d), i == 0 ? 21'h10 : 21'h0);
    end
    chk("reset controls", ctl, ctl_exp(8'h10, 3'h0, 2'h0));
  endtask
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    results();
  end
  // main sequence
  initial begin
    seed = 32'h03e00c5e;
    rst_n = 1'b0;
    user_gain = 3'h0;
    amplifier_enable = 2'h0;
    reset_check();
    for (int i = 0; i < 16; i++) begin
      s = 8'($random(seed));
      s[7:5] = i[2:0];
      g = 3'($random(seed));
      a = 2'($random(seed));
      if (i < 8) begin
        g = g & 3'h2;
        a = 2'h1;
      end
      @(posedge sys_clk);
      user_gain <= g;
      amplifier_enable <= a;
      // odd passes leave an idle cycle, even passes read back to back
      if (i[0]) begin
        i_host_model.wr(8'h09, s);
        i_host_model.rd(8'h09, d);
      end else begin
        i_host_model.wr_rd(8'h09, s, d);
      end
      chk("system control", 21'(d), 21'(s));
      chk("controls", ctl, ctl_exp(s, g, a));
    end
    for (int k = 0; k < 4; k++) begin
      o = (k == 0) ? 16'hFFFF : 16'($random(seed));
      i_host_model.wr(8'h0B, o[7:0]);
      i_host_model.wr(8'h0C, o[15:8]);
      i_host_model.rd(8'h0B, d);
      chk("offset low", 21'(d), 21'(o[7:0]));
      chk("offset word", 21'(offset_correction_value), 21'(o));
    end
    i_host_model.wr(8'h0A, 8'h00);
    i_host_model.wr(8'h30, 8'hFF);
    i_host_model.rd(8'h0A, d);
    chk("reserved", 21'(d), 21'h0);
    i_host_model.rd(8'h30, d);
    chk("unmapped", 21'(d), 21'h0);
    reset_check();
    results();
  end
endmodule // adc_system_control_regs_tb_top
